// ---- core/hsc_pkg.sv ----
// Constants, codes and types for the humidity sensor command port.
// Assumes a single 10 MHz core clock and a bus far slower than it.
// Function
// - Answer as I2C target at address 0x40.
// - 0xE5 starts humidity conversion, clock stretched.
// - 0xF5 starts humidity conversion, no stretching.
// - 0xE3 starts temperature conversion, clock stretched.
// - 0xF3 starts temperature conversion, no stretching.
// - 0xE0 returns temperature from last humidity run.
// - 0xE6 plus byte writes configuration register.
// - 0xE7 makes next read return configuration.
// - 0xFA 0x0F selects first identification half.
// - 0xFC 0xC9 selects second identification half.
// - Command code alone picks stretch or NACK wait.
// - Stretch mode: hold clock, then MSB, LSB.
// - Poll mode: NACK read address until done.
// - Running poll conversion NACKs own read address.
// - Acked measurement LSB is followed by checksum.
// - NACKed LSB ends transfer without checksum.
// - Checksum is CRC-8 0x31, start 0x00.
// - Identification reads always carry checksum bytes.
// - Only measure and identification commands give checksum.
// - Humidity LSB low bits read 10.
// - Temperature LSB low bits read 00.
package hsc_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic [7:0] CMD_RH_HOLD = 8'he5;
  localparam logic [7:0] CMD_RH_POLL = 8'hf5;
  localparam logic [7:0] CMD_T_HOLD = 8'he3;
  localparam logic [7:0] CMD_T_POLL = 8'hf3;
  localparam logic [7:0] CMD_T_PREV = 8'he0;
  localparam logic [7:0] CMD_RESET = 8'hfe;
  localparam logic [7:0] CMD_CFG_WR = 8'he6;
  localparam logic [7:0] CMD_CFG_RD = 8'he7;
  localparam logic [7:0] CMD_IDA = 8'hfa;
  localparam logic [7:0] CMD_IDA2 = 8'h0f;
  localparam logic [7:0] CMD_IDB = 8'hfc;
  localparam logic [7:0] CMD_IDB2 = 8'hc9;
  localparam logic [7:0] CMD_FW = 8'h84;
  localparam logic [7:0] CMD_FW2 = 8'hb8;
  localparam logic [7:0] FW_REV = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h3a;
  localparam logic [7:0] CFG_WR_MASK = 8'h85;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [1:0] HUM_TAG = 2'b10;
  localparam logic [1:0] TEMP_TAG = 2'b00;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] RD_LSB = 4'h1;
  localparam logic [3:0] RD_CRC = 4'h2;
  localparam logic [3:0] IDA_LAST = 4'h7;
  localparam logic [3:0] IDB_LAST = 4'h5;
  localparam int CLK_MHZ = 10;
  localparam int CONV_TIME_US = 100;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_HOLD, ST_TX, ST_MACK} hsc_state_e;
  typedef enum logic [2:0] {SEL_NONE, SEL_MEAS, SEL_TPREV, SEL_CFG, SEL_IDA, SEL_IDB,
                            SEL_FW} hsc_sel_e;
endpackage : hsc_pkg

// ---- core/hsc_cmd_port.sv ----
// Target-side I2C command port of a humidity and temperature sensor.
// Assumes open-drain SCL/SDA resolved outside; sensor codes valid on core_clk.
`timescale 1ns/1ps
`default_nettype none
module hsc_cmd_port #(
  parameter logic [31:0] ID_SER_A = 32'h0123_4567, // Arbitrary identification value
  parameter logic [31:0] ID_SER_B = 32'h89ab_cdef  // Arbitrary identification value
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [15:0] rh_code_in,
  input wire logic [15:0] temp_code_in,
  output logic conv_busy,
  output logic [7:0] user_cfg
);

  // CRC-8 step over one byte, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ hsc_pkg::CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc8

  // Read byte table: {is checksum, is last, data}
  function automatic logic [9:0] rd_byte(input hsc_pkg::hsc_sel_e s, input logic [3:0] i,
      input logic [15:0] m, input logic [15:0] t, input logic [7:0] c);
    logic [9:0] r;
    r = {1'b0, 1'b1, hsc_pkg::IDLE_BYTE};
    unique case (s)
      hsc_pkg::SEL_MEAS: begin
        if (i == hsc_pkg::RD_CRC) r = {1'b1, 1'b1, hsc_pkg::IDLE_BYTE};
        else r = {1'b0, 1'b0, (i == hsc_pkg::RD_LSB) ? m[7:0] : m[15:8]};
      end
      hsc_pkg::SEL_TPREV: r = {1'b0, i == hsc_pkg::RD_LSB,
                               (i == hsc_pkg::RD_LSB) ? t[7:0] : t[15:8]};
      hsc_pkg::SEL_CFG: r = {1'b0, 1'b1, c};
      hsc_pkg::SEL_FW: r = {1'b0, 1'b1, hsc_pkg::FW_REV};
      hsc_pkg::SEL_IDA: begin
        // Each serial byte is followed by a checksum
        r = {i[0], i == hsc_pkg::IDA_LAST, ID_SER_A[8*(3-i[2:1]) +: 8]};
      end
      hsc_pkg::SEL_IDB: begin
        // Two serial bytes, then a checksum, twice
        if (i == 4'h2 || i == hsc_pkg::IDB_LAST) r = {1'b1, i == hsc_pkg::IDB_LAST, hsc_pkg::IDLE_BYTE};
        else r = {1'b0, 1'b0, ID_SER_B[8*(3-((i > 4'h2) ? i - 4'h1 : i)) +: 8]};
      end
      default: r = {1'b0, 1'b1, hsc_pkg::IDLE_BYTE};
    endcase
    return r;
  endfunction : rd_byte

  hsc_pkg::hsc_state_e st_r;
  hsc_pkg::hsc_sel_e sel_r;
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic scl_f_r;
  logic sda_f_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sr_r;
  logic [7:0] tx_sr_r;
  logic is_addr_r;
  logic rw_r;
  logic [1:0] byte_idx_r;
  logic [7:0] cmd_r;
  logic [3:0] rd_idx_r;
  logic [7:0] crc_r;
  logic last_r;
  logic mack_r;
  logic [7:0] cfg_r;
  logic sda_oe_r;
  logic scl_oe_r;
  logic busy_r;
  logic hold_r;
  logic hum_r;
  logic [15:0] cnt_r;
  logic [15:0] meas_r;
  logic [15:0] tprev_r;

  // Filtered bus levels: a change counts once stages two and three agree
  wire scl_new = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_f_r;
  wire sda_new = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_f_r;
  wire scl_rise = scl_new & ~scl_f_r;
  wire scl_fall = ~scl_new & scl_f_r;
  wire start_det = scl_new & scl_f_r & sda_f_r & ~sda_new;
  wire stop_det = scl_new & scl_f_r & ~sda_f_r & sda_new;

  // Byte-level decode of the received byte
  wire byte_done = (st_r == hsc_pkg::ST_RX) && scl_fall && (bit_cnt_r == hsc_pkg::BITS_BYTE);
  wire addr_hit = rx_sr_r[7:1] == hsc_pkg::DEV_ADDR;
  wire poll_nack = rx_sr_r[0] && busy_r && !hold_r;
  wire cmd_stb = byte_done && !is_addr_r && (byte_idx_r == 2'h0);
  wire is_meas = (rx_sr_r == hsc_pkg::CMD_RH_HOLD) || (rx_sr_r == hsc_pkg::CMD_RH_POLL) ||
                 (rx_sr_r == hsc_pkg::CMD_T_HOLD) || (rx_sr_r == hsc_pkg::CMD_T_POLL);
  wire is_hum = (rx_sr_r == hsc_pkg::CMD_RH_HOLD) || (rx_sr_r == hsc_pkg::CMD_RH_POLL);
  wire is_hold = (rx_sr_r == hsc_pkg::CMD_RH_HOLD) || (rx_sr_r == hsc_pkg::CMD_T_HOLD);
  wire is_rst = rx_sr_r == hsc_pkg::CMD_RESET;
  wire conv_end = busy_r && (cnt_r == 16'(hsc_pkg::CONV_CYCLES - 1));

  // Next outgoing byte and checksum chaining
  wire [9:0] fetch = rd_byte(sel_r, rd_idx_r, meas_r, tprev_r, cfg_r);
  wire [7:0] crc_base = (rd_idx_r == 4'h0) ? hsc_pkg::CRC_INIT : crc_r;
  wire [7:0] ld_byte = fetch[9] ? crc_base : fetch[7:0];
  wire [7:0] crc_upd = fetch[9] ? crc_base : crc8(crc_base, fetch[7:0]);

  // Three-stage synchronisers on both bus lines
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_i};
      sda_sync_r <= {sda_sync_r[1:0], sda_i};
      scl_f_r <= scl_new;
      sda_f_r <= sda_new;
    end
  end

  // Conversion timer; the sensor codes are only sampled at the end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      hold_r <= 1'b0;
      hum_r <= 1'b0;
      cnt_r <= 16'h0000;
      meas_r <= 16'h0000;
      tprev_r <= 16'h0000;
    end else if (cmd_stb && is_meas) begin
      busy_r <= 1'b1;
      hold_r <= is_hold;
      hum_r <= is_hum;
      cnt_r <= 16'h0000;
    end else if (cmd_stb && is_rst) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 16'h0001;
      if (conv_end) begin
        busy_r <= 1'b0;
        meas_r <= hum_r ? {rh_code_in[15:2], hsc_pkg::HUM_TAG}
                        : {temp_code_in[15:2], hsc_pkg::TEMP_TAG};
        if (hum_r) tprev_r <= {temp_code_in[15:2], hsc_pkg::TEMP_TAG};
      end
    end
  end

  // Bus protocol engine; transmit bits change while SCL is low, except the first bit after a stretch, which changes in the cycle SCL is let go
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= hsc_pkg::ST_IDLE;
      sel_r <= hsc_pkg::SEL_NONE;
      bit_cnt_r <= 4'h0;
      rx_sr_r <= 8'h00;
      tx_sr_r <= 8'h00;
      is_addr_r <= 1'b0;
      rw_r <= 1'b0;
      byte_idx_r <= 2'h0;
      cmd_r <= 8'h00;
      rd_idx_r <= 4'h0;
      crc_r <= hsc_pkg::CRC_INIT;
      last_r <= 1'b0;
      mack_r <= 1'b0;
      cfg_r <= hsc_pkg::CFG_RESET;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else if (start_det) begin
      // Start or repeated start always restarts address reception
      st_r <= hsc_pkg::ST_RX;
      bit_cnt_r <= 4'h0;
      is_addr_r <= 1'b1;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= hsc_pkg::ST_IDLE;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        hsc_pkg::ST_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        hsc_pkg::ST_RX: begin
          if (scl_rise) begin
            rx_sr_r <= {rx_sr_r[6:0], sda_new};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            if (is_addr_r) begin
              // Foreign address or busy poll read: stay silent until next start
              if (addr_hit && !poll_nack) begin
                sda_oe_r <= 1'b1;
                st_r <= hsc_pkg::ST_ACK;
                rw_r <= rx_sr_r[0];
                byte_idx_r <= 2'h0;
                rd_idx_r <= 4'h0;
              end else begin
                st_r <= hsc_pkg::ST_IDLE;
              end
            end else begin
              sda_oe_r <= 1'b1;
              st_r <= hsc_pkg::ST_ACK;
              if (byte_idx_r != 2'h3) byte_idx_r <= byte_idx_r + 2'h1;
              if (byte_idx_r == 2'h0) begin
                cmd_r <= rx_sr_r;
                // Unlisted codes are acknowledged and leave the selection alone
                if (is_meas) sel_r <= hsc_pkg::SEL_MEAS;
                else if (rx_sr_r == hsc_pkg::CMD_T_PREV) sel_r <= hsc_pkg::SEL_TPREV;
                else if (rx_sr_r == hsc_pkg::CMD_CFG_RD) sel_r <= hsc_pkg::SEL_CFG;
                else if (is_rst) begin
                  sel_r <= hsc_pkg::SEL_NONE;
                  cfg_r <= hsc_pkg::CFG_RESET;
                end
              end else if (byte_idx_r == 2'h1) begin
                if (cmd_r == hsc_pkg::CMD_CFG_WR) begin
                  // Read-only and reserved bits keep their values
                  cfg_r <= (cfg_r & ~hsc_pkg::CFG_WR_MASK) |
                           (rx_sr_r & hsc_pkg::CFG_WR_MASK);
                end else if (cmd_r == hsc_pkg::CMD_IDA && rx_sr_r == hsc_pkg::CMD_IDA2) begin
                  sel_r <= hsc_pkg::SEL_IDA;
                end else if (cmd_r == hsc_pkg::CMD_IDB && rx_sr_r == hsc_pkg::CMD_IDB2) begin
                  sel_r <= hsc_pkg::SEL_IDB;
                end else if (cmd_r == hsc_pkg::CMD_FW && rx_sr_r == hsc_pkg::CMD_FW2) begin
                  sel_r <= hsc_pkg::SEL_FW;
                end
              end
            end
          end
        end
        hsc_pkg::ST_ACK: begin
          if (scl_fall) begin
            is_addr_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            if (!rw_r) begin
              sda_oe_r <= 1'b0;
              st_r <= hsc_pkg::ST_RX;
            end else if (busy_r) begin
              // Hold-mode conversion still running: stretch the clock
              sda_oe_r <= 1'b0;
              scl_oe_r <= 1'b1;
              st_r <= hsc_pkg::ST_HOLD;
            end else begin
              tx_sr_r <= ld_byte;
              crc_r <= crc_upd;
              last_r <= fetch[8];
              rd_idx_r <= rd_idx_r + 4'h1;
              sda_oe_r <= ~ld_byte[7];
              st_r <= hsc_pkg::ST_TX;
            end
          end
        end
        hsc_pkg::ST_HOLD: begin
          if (!busy_r) begin
            // Data bit set up in the same cycle that SCL is let go
            tx_sr_r <= ld_byte;
            crc_r <= crc_upd;
            last_r <= fetch[8];
            rd_idx_r <= rd_idx_r + 4'h1;
            sda_oe_r <= ~ld_byte[7];
            scl_oe_r <= 1'b0;
            st_r <= hsc_pkg::ST_TX;
          end
        end
        hsc_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == hsc_pkg::BIT_LAST) begin
              sda_oe_r <= 1'b0;
              st_r <= hsc_pkg::ST_MACK;
            end else begin
              tx_sr_r <= {tx_sr_r[6:0], 1'b0};
              sda_oe_r <= ~tx_sr_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        hsc_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_new;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (mack_r && !last_r) begin
              tx_sr_r <= ld_byte;
              crc_r <= crc_upd;
              last_r <= fetch[8];
              rd_idx_r <= rd_idx_r + 4'h1;
              sda_oe_r <= ~ld_byte[7];
              st_r <= hsc_pkg::ST_TX;
            end else begin
              st_r <= hsc_pkg::ST_IDLE;
            end
          end
        end
        // Unused state codes fall back to idle rather than lock the bus
        default: st_r <= hsc_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain outputs: the pin level driven is always low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // Status mirrors are one cycle behind the internal state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      conv_busy <= 1'b0;
      user_cfg <= hsc_pkg::CFG_RESET;
    end else begin
      scl_oe <= scl_oe_r;
      sda_oe <= sda_oe_r;
      conv_busy <= busy_r;
      user_cfg <= cfg_r;
    end
  end

endmodule : hsc_cmd_port
`default_nettype wire

// ---- dv/hsc_cmd_port_sva.sv ----
// Pin-level checks for the sensor command port.
// Assumes one clock domain; attached to every port instance by bind.
`timescale 1ns/1ps
`default_nettype none
module hsc_cmd_port_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic conv_busy,
  input wire logic [7:0] user_cfg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  int busy_n;
  // Conversion length; a stuck busy flag would hang a stretching host
  always_ff @(posedge core_clk) begin
    busy_n <= (!rst_n || !conv_busy) ? 0 : busy_n + 1;
  end
  sequence s_busy_end;
    $fell(conv_busy);
  endsequence
  sequence s_quiet;
    !conv_busy [*4];
  endsequence
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("Device drives a bus line high");
  a_sda_steady: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("Data line moved while clock high");
  a_stretch_cause: assert property ($rose(scl_oe) |-> conv_busy)
    else $error("Clock stretch without a conversion");
  a_stretch_end: assert property (s_busy_end |-> ##[0:4] !scl_oe)
    else $error("Clock held after conversion end");
  a_stretch_idle: assert property (s_quiet |-> !scl_oe)
    else $error("Clock held while idle");
  a_busy_min: assert property ($rose(conv_busy) |-> conv_busy [*8])
    else $error("Conversion ended at once");
  a_busy_max: assert property (conv_busy |-> busy_n <= 1100)
    else $error("Conversion never ends");
  a_cfg_fixed: assert property ((user_cfg & 8'h7a) == 8'h3a)
    else $error("Fixed configuration bits changed");
endmodule : hsc_cmd_port_chk
bind hsc_cmd_port hsc_cmd_port_chk u_hsc_cmd_port_chk (
  .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe), .conv_busy(conv_busy), .user_cfg(user_cfg)
);
`default_nettype wire

// ---- dv/hsc_i2c_host.sv ----
// Behavioural I2C controller facing the sensor's bus pins.
// Assumes pull-ups on both wires; tasks are called at falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module hsc_i2c_host (
  input wire logic core_clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl_i,
  output logic sda_i
);
  logic scl_h = 1'b1;
  logic sda_h = 1'b1;
  // Wired-AND with pull-ups: a released line reads high
  assign scl_i = scl_h & ~scl_oe;
  assign sda_i = sda_h & ~sda_oe;
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt
  // Release SCL, wait out a stretch (bounded), then hold high
  task automatic rise;
    int k;
    k = 0;
    scl_h = 1'b1;
    while (!scl_i && k < 3000) begin
      wt(1);
      k++;
    end
    wt(6);
  endtask : rise
  // Data changes only in the low phase, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    wt(6);
    rise();
    r = sda_i;
    wt(6);
    scl_h = 1'b0;
    wt(6);
  endtask : bit_io
  task automatic start;
    sda_h = 1'b1;
    wt(6);
    rise();
    sda_h = 1'b0;
    wt(6);
    scl_h = 1'b0;
    wt(6);
  endtask : start
  task automatic stop;
    sda_h = 1'b0;
    wt(6);
    rise();
    sda_h = 1'b1;
    wt(12);
  endtask : stop
  // Byte then acknowledge slot; mack low acknowledges a read byte
  task automatic xfer(input logic [7:0] wb, input logic mack, output logic [7:0] rb,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(wb[i], rb[i]);
    bit_io(mack, ack);
  endtask : xfer
endmodule : hsc_i2c_host
`default_nettype wire

// ---- dv/hsc_cmd_port_test.sv ----
// Self-checking bench for the sensor command port.
// Assumes the behavioural controller model drives the bus pins.
`timescale 1ns/1ps
`default_nettype none
module hsc_cmd_port_test;
  localparam logic [31:0] ID_A = 32'h2468_ace1; // Arbitrary identification value
  localparam logic [31:0] ID_B = 32'h1357_9bdf; // Arbitrary identification value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl_i, sda_i, scl_o, sda_o, scl_oe, sda_oe, conv_busy, ack;
  logic [15:0] rh_code_in = 16'h0000;
  logic [15:0] temp_code_in = 16'h0000;
  logic [15:0] tprev, w;
  logic [7:0] user_cfg, rb, cfg_e;
  logic [31:0] rnd = 32'h71dd0ed7;
  logic [7:0] exp_q[$];
  logic [7:0] sq[$];
  logic [7:0] mc[4] = '{8'he5, 8'hf5, 8'he3, 8'hf3};
  int fail_count = 0;
  int n_tests = 0;
  int k;
  hsc_cmd_port #(.ID_SER_A(ID_A), .ID_SER_B(ID_B)) u_hsc_cmd_port (.core_clk(core_clk),
    .rst_n(rst_n), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .rh_code_in(rh_code_in), .temp_code_in(temp_code_in),
    .conv_busy(conv_busy), .user_cfg(user_cfg));
  hsc_i2c_host u_hsc_i2c_host (.core_clk(core_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_i(scl_i), .sda_i(sda_i));
  initial forever #50 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Bitwise CRC-8, polynomial 0x31, start 0x00
  function automatic logic [7:0] crc8(input logic [7:0] q[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) begin
      c = c ^ q[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // Written byte with the expected acknowledge level
  task automatic wb(input logic [7:0] b, input logic e_ack);
    u_hsc_i2c_host.xfer(b, 1'b1, rb, ack);
    chk({7'h00, ack}, {7'h00, e_ack});
  endtask : wb
  task automatic wcmd(input logic [7:0] c, input logic [7:0] c2, input bit two);
    u_hsc_i2c_host.start();
    wb(8'h80, 1'b0);
    wb(c, 1'b0);
    if (two) wb(c2, 1'b0);
  endtask : wcmd
  task automatic raddr(input logic e);
    u_hsc_i2c_host.start();
    wb(8'h81, e);
  endtask : raddr
  // Read the whole expected queue, refusing the last byte
  task automatic rdq;
    for (int i = 0; i < exp_q.size(); i++) begin
      u_hsc_i2c_host.xfer(8'hff, i == exp_q.size() - 1, rb, ack);
      chk(rb, exp_q[i]);
    end
    u_hsc_i2c_host.stop();
  endtask : rdq
  // Identification read; a checksum after every step serial bytes
  task automatic idrd(input logic [7:0] c, input logic [7:0] c2, input logic [31:0] v,
                      input int step);
    wcmd(c, c2, 1'b1);
    raddr(1'b0);
    sq = {};
    exp_q = {};
    for (int j = 3; j >= 0; j--) begin
      sq.push_back(v[8*j +: 8]);
      exp_q.push_back(v[8*j +: 8]);
      if (j % step == 0) exp_q.push_back(crc8(sq));
    end
    rdq();
  endtask : idrd
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    u_hsc_i2c_host.wt(8);
    chk(user_cfg, 8'h3a);
    u_hsc_i2c_host.start();
    wb(8'h82, 1'b1);
    u_hsc_i2c_host.stop();
    // Configuration write, then read back with one byte past the end
    rnd = lfsr(rnd);
    cfg_e = (rnd[7:0] & 8'h85) | 8'h3a;
    wcmd(8'he6, 8'h00, 1'b0);
    wb(rnd[7:0], 1'b0);
    u_hsc_i2c_host.stop();
    chk(user_cfg, cfg_e);
    wcmd(8'he7, 8'h00, 1'b0);
    raddr(1'b0);
    exp_q = '{cfg_e, 8'hff};
    rdq();
    // Every measure code; checksum taken on even runs only
    foreach (mc[i]) begin
      rnd = lfsr(rnd);
      rh_code_in = rnd[15:0];
      temp_code_in = rnd[31:16];
      wcmd(mc[i], 8'h00, 1'b0);
      if (mc[i][4]) begin
        u_hsc_i2c_host.stop();
        raddr(1'b1);
        u_hsc_i2c_host.stop();
        k = 0;
        do begin
          u_hsc_i2c_host.start();
          u_hsc_i2c_host.xfer(8'h81, 1'b1, rb, ack);
          if (ack) u_hsc_i2c_host.stop();
          k++;
        end while (ack && k < 20);
        chk({7'h00, ack}, 8'h00);
      end else begin
        raddr(1'b0);
      end
      w = mc[i][1] ? {temp_code_in[15:2], 2'b00} : {rh_code_in[15:2], 2'b10};
      if (!mc[i][1]) tprev = temp_code_in;
      exp_q = '{w[15:8], w[7:0]};
      if (i % 2 == 0) exp_q.push_back(crc8(exp_q));
      rdq();
    end
    // Temperature kept from the last humidity run, no checksum
    rnd = lfsr(rnd);
    temp_code_in = rnd[15:0];
    wcmd(8'he0, 8'h00, 1'b0);
    raddr(1'b0);
    exp_q = '{tprev[15:8], {tprev[7:2], 2'b00}, 8'hff};
    rdq();
    idrd(8'hfa, 8'h0f, ID_A, 1);
    idrd(8'hfc, 8'hc9, ID_B, 2);
    // Reset command in mid-conversion
    wcmd(8'hf5, 8'h00, 1'b0);
    u_hsc_i2c_host.stop();
    wcmd(8'hfe, 8'h00, 1'b0);
    u_hsc_i2c_host.stop();
    u_hsc_i2c_host.wt(4);
    chk({7'h00, conv_busy}, 8'h00);
    chk(user_cfg, 8'h3a);
    close_out();
  end
endmodule : hsc_cmd_port_test
`default_nettype wire
